// >>> core/pwm_output_generator.sv
`timescale 1ns/100ps
// Summary of operation
// - programmable 8-bit prescaler clocks the counter
// - prescaler count is private, counter value is a status output
// - counter runs 0 to 254, wraps
// - output goes high on compare match
// - output goes low at counter zero
// - compare zero keeps output always high
// - compare 255 keeps output always low
// - counter steps every 2*(1+prescale) oscillator cycles
// - low/high ratio is compare/(255-compare)
// - enabled output drives strong high level
// - disabled pin is port bit, counter runs
// - reset clears enable until software sets
// - pin held high in idle/power-down
// - counter frozen during idle mode
// - overflow raises interrupt when not masked
// - interrupt still works with output disabled
module pwm_output_generator (
  // clock and reset (clock is oscillator divided by two)
  input wire logic clock,
  input wire logic srst,
  // software writes
  input wire logic prescaleWrite,
  input wire logic compareWrite,
  input wire logic enableWrite,
  input wire logic [pwm_output_pkg::DATA_W-1:0] writeData,
  input wire logic waveform_irq_enable,
  // power modes
  input wire logic idleMode,
  input wire logic powerDown,
  // ordinary port bit
  input wire logic portLatch,
  // pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic pinPullup,
  output logic portPinValue,
  // status
  output logic [pwm_output_pkg::DATA_W-1:0] waveform_prescale_reg,
  output logic [pwm_output_pkg::DATA_W-1:0] compareReg,
  output logic waveform_output_enable_reg,
  output logic [pwm_output_pkg::DATA_W-1:0] counterValue,
  output logic waveLevel,
  output logic overflowPulse,
  output logic irqRequest
);
  import pwm_output_pkg::*;

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  power_mode_t mode;
  logic step;
  logic next_waveLevel;
  logic next_overflowPulse;
  logic [DATA_W-1:0] next_counterValue;
  logic [DATA_W-1:0] next_prescale;
  logic [DATA_W-1:0] next_compare;
  logic next_enable;
  logic pinSync0;
  logic pinSync1;

  always_comb begin
    if (powerDown) begin
      mode = MODE_DOWN;
    end else if (idleMode) begin
      mode = MODE_IDLE;
    end else begin
      mode = MODE_RUN;
    end
  end

  // ---------------------------------------------
  // prescaler
  // ---------------------------------------------
  pwm_prescaler u_prescaler (
    .clock(clock),
    .srst(srst),
    .run(mode == MODE_RUN),
    .reload(waveform_prescale_reg),
    .step(step)
  );

  // ---------------------------------------------
  // control registers
  // ---------------------------------------------
  always_comb begin
    next_prescale = prescaleWrite ? writeData : waveform_prescale_reg;
    next_compare = compareWrite ? writeData : compareReg;
    next_enable = enableWrite ? writeData[0] : waveform_output_enable_reg;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      waveform_prescale_reg <= PRESCALE_RESET;
      compareReg <= COMPARE_RESET;
      waveform_output_enable_reg <= OUT_ENABLE_RESET;
    end else begin
      waveform_prescale_reg <= next_prescale;
      compareReg <= next_compare;
      waveform_output_enable_reg <= next_enable;
    end
  end

  // ---------------------------------------------
  // counter and waveform
  // ---------------------------------------------
  always_comb begin
    next_counterValue = counterValue;
    next_waveLevel = waveLevel;
    next_overflowPulse = 1'b0;
    if (step) begin
      if (counterValue == COUNT_LAST) begin
        next_counterValue = COUNT_ZERO;
        next_overflowPulse = 1'b1;
      end else begin
        next_counterValue = counterValue + 8'h01;
      end
      // match wins over zero so compare 0 stays high
      if (next_counterValue == compareReg) begin
        next_waveLevel = 1'b1;
      end else if (next_counterValue == COUNT_ZERO) begin
        next_waveLevel = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      counterValue <= COUNT_ZERO;
      waveLevel <= 1'b1;
      overflowPulse <= 1'b0;
    end else begin
      counterValue <= next_counterValue;
      waveLevel <= next_waveLevel;
      overflowPulse <= next_overflowPulse;
    end
  end

  // ---------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      pinSync0 <= 1'b1;
      pinSync1 <= 1'b1;
    end else begin
      pinSync0 <= pinIn;
      pinSync1 <= pinSync0;
    end
  end

  // ---------------------------------------------
  // pin drive and interrupt
  // ---------------------------------------------
  always_comb begin
    irqRequest = overflowPulse & waveform_irq_enable;
    portPinValue = pinSync1;
    if (mode != MODE_RUN) begin
      pinOut = 1'b1;
      pinOe = 1'b1;
      pinPullup = 1'b0;
    end else if (waveform_output_enable_reg) begin
      pinOut = waveLevel;
      pinOe = 1'b1;
      pinPullup = 1'b0;
    end else begin
      pinOut = 1'b0;
      pinOe = ~portLatch;
      pinPullup = portLatch;
    end
  end
endmodule // pwm_output_generator

// >>> core/pwm_output_pkg.sv
package pwm_output_pkg;
  // ---------------------------------------------
  // widths and reset values
  // ---------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic OUT_ENABLE_RESET = 1'b0;
  // ---------------------------------------------
  // counter limits
  // ---------------------------------------------
  localparam logic [7:0] COUNT_LAST = 8'hfe;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COMPARE_NEVER = 8'hff;
  // oscillator is divided by two before this block sees it
  localparam int OSC_PER_STEP_BASE = 2;
  // ---------------------------------------------
  // power modes
  // ---------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_DOWN = 3'b100
  } power_mode_t;
endpackage

// >>> core/pwm_prescaler.sv
`timescale 1ns/100ps
// one-cycle step pulse every (1 + reload) clock cycles
module pwm_prescaler (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic [pwm_output_pkg::DATA_W-1:0] reload,
  // step pulse
  output logic step
);
  import pwm_output_pkg::*;

  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] next_count;

  always_comb begin
    next_count = count;
    step = 1'b0;
    if (run) begin
      if (count >= reload) begin
        next_count = '0;
        step = 1'b1;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // pwm_prescaler

// >>> tb/pwm_load.sv
`timescale 1ns/100ps
// external load: a released pin without pull-up shows a changing level
module pwm_load (
  input wire logic clock,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic pinPullup,
  output logic level
);
  logic last = 1'b0;
  always_comb level = pinOe ? pinOut : (pinPullup ? 1'b1 : ~last);
  always @(posedge clock) last <= level;
endmodule // pwm_load

// >>> tb/pwm_output_generator_tb.sv
`timescale 1ns/100ps
module pwm_output_generator_tb;
  logic clock = 0, srst = 1, prescaleWrite = 0, compareWrite = 0, enableWrite = 0, pinIn;
  logic waveform_irq_enable = 0, idleMode = 0, powerDown = 0, portLatch = 1;
  logic [7:0] writeData = 8'h00, waveform_prescale_reg, compareReg, counterValue;
  logic pinOut, pinOe, pinPullup, portPinValue, waveform_output_enable_reg, waveLevel, overflowPulse, irqRequest;
  int failures = 0, n_compared = 0, cyc = 0, n;
  always #50 clock = ~clock;
  pwm_output_generator u_pwm_output_generator (
    .clock(clock),
    .srst(srst),
    .prescaleWrite(prescaleWrite),
    .compareWrite(compareWrite),
    .enableWrite(enableWrite),
    .writeData(writeData),
    .waveform_irq_enable(waveform_irq_enable),
    .idleMode(idleMode),
    .powerDown(powerDown),
    .portLatch(portLatch),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pinPullup(pinPullup),
    .portPinValue(portPinValue),
    .waveform_prescale_reg(waveform_prescale_reg),
    .compareReg(compareReg),
    .waveform_output_enable_reg(waveform_output_enable_reg),
    .counterValue(counterValue),
    .waveLevel(waveLevel),
    .overflowPulse(overflowPulse),
    .irqRequest(irqRequest)
  );
  pwm_load u_pwm_load (.clock(clock), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup), .level(pinIn));
  task check(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task summarize;
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input int k, input logic [7:0] d);
    @(posedge clock);
    writeData <= d;
    prescaleWrite <= k == 0;
    compareWrite <= k == 1;
    enableWrite <= k == 2;
    @(posedge clock);
    {prescaleWrite, compareWrite, enableWrite} <= 3'b000;
  endtask
  task sync;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (overflowPulse !== 1'b1 && n < 2000);
  endtask
  task t_period;
    portLatch <= 1'b0;
    waveform_irq_enable <= 1'b1;
    wr(0, 8'h02);
    sync;
    sync;
    check(n == 765 && irqRequest === 1'b1, "period or irq");
    check(pinOe === 1'b1 && pinOut === 1'b0 && portPinValue === 1'b0, "port drive");
    check(waveform_prescale_reg === 8'h02, "prescale");
    waveform_irq_enable <= 1'b0;
    sync;
    check(irqRequest === 1'b0, "irq not masked");
    portLatch <= 1'b1;
    repeat (3) @(posedge clock);
    check(pinOe === 1'b0 && pinPullup === 1'b1 && portPinValue === 1'b1, "port pull-up");
  endtask
  task t_duty(input logic [7:0] c);
    int hi;
    wr(1, c);
    sync;
    sync;
    hi = 0;
    repeat (255) begin
      @(posedge clock);
      hi += pinOut;
    end
    check(hi == (c == 8'hff ? 0 : 255 - c) && pinOe === 1'b1, "duty");
  endtask
  task t_idle;
    logic [7:0] v;
    idleMode <= 1'b1;
    repeat (3) @(posedge clock);
    v = counterValue;
    repeat (20) @(posedge clock);
    check(counterValue === v && pinOut === 1'b1 && pinOe === 1'b1, "idle");
    idleMode <= 1'b0;
    powerDown <= 1'b1;
    repeat (2) @(posedge clock);
    check(pinOut === 1'b1 && pinOe === 1'b1, "power down pin");
    powerDown <= 1'b0;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      summarize;
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check(waveform_output_enable_reg === 1'b0 && compareReg === 8'h00 && counterValue === 8'h00, "reset");
    t_period;
    wr(0, 8'h00);
    wr(2, 8'h01);
    t_duty(8'h00);
    t_duty(8'h40);
    t_duty(8'hff);
    t_idle;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check(waveform_output_enable_reg === 1'b0 && counterValue === 8'h00 && pinOe === 1'b0, "reset again");
    summarize;
  end
endmodule // pwm_output_generator_tb

// >>> tb/pwm_output_props.sv
`timescale 1ns/100ps
module pwm_output_props (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // inputs watched
  input wire logic idleMode,
  input wire logic powerDown,
  input wire logic portLatch,
  input wire logic waveform_irq_enable,
  // outputs watched
  input wire logic waveform_output_enable_reg,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic waveLevel,
  input wire logic overflowPulse,
  input wire logic irqRequest,
  input wire logic [7:0] counterValue,
  input wire logic [7:0] compareReg
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence idle3; idleMode [*3]; endsequence
  sequence moved; $changed(counterValue); endsequence
  a_count_range: assert property (counterValue != 8'hff)
    else $error("counter out of range");
  a_wrap_flag: assert property (overflowPulse |-> counterValue == 8'h00 && $past(counterValue) == 8'hfe)
    else $error("bad overflow");
  a_irq_gate: assert property (irqRequest == (overflowPulse && waveform_irq_enable))
    else $error("bad irq");
  a_idle_freeze: assert property (idle3 |-> $stable(counterValue))
    else $error("counter moved in idle");
  a_sleep_pin: assert property (idleMode || powerDown |-> pinOut && pinOe)
    else $error("pin not high");
  a_drive_wave: assert property (waveform_output_enable_reg && !idleMode && !powerDown |-> pinOe && pinOut == waveLevel)
    else $error("wave not driven");
  a_port_mode: assert property (!waveform_output_enable_reg && !idleMode && !powerDown |-> pinOe == !portLatch)
    else $error("port mode wrong");
  a_match_high: assert property (moved and counterValue == compareReg && $stable(compareReg) |-> waveLevel)
    else $error("no high on match");
  a_zero_low: assert property (moved and counterValue == 8'h00 && compareReg != 8'h00 && $stable(compareReg)
    |-> !waveLevel)
    else $error("no low at zero");
  a_reset_off: assert property ($past(srst) |-> !waveform_output_enable_reg)
    else $error("enabled after reset");
endmodule // pwm_output_props
bind pwm_output_generator pwm_output_props u_pwm_output_props (
  .clock(clock),
  .srst(srst),
  .idleMode(idleMode),
  .powerDown(powerDown),
  .portLatch(portLatch),
  .waveform_irq_enable(waveform_irq_enable),
  .waveform_output_enable_reg(waveform_output_enable_reg),
  .pinOut(pinOut),
  .pinOe(pinOe),
  .waveLevel(waveLevel),
  .overflowPulse(overflowPulse),
  .irqRequest(irqRequest),
  .counterValue(counterValue),
  .compareReg(compareReg)
);
